// >>> tsab_pkg.sv
package tsab_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned TSAB_NBTN = 10;
  localparam int unsigned TSAB_CLK_HZ = 10000000;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] TSAB_ADR_LIVE_LOW = 4'h0;
  localparam logic [3:0] TSAB_ADR_LIVE_HIGH = 4'h1;
  localparam logic [3:0] TSAB_ADR_HELD_LOW = 4'h2;
  localparam logic [3:0] TSAB_ADR_HELD_HIGH = 4'h3;
  localparam logic [3:0] TSAB_ADR_LED_CFG = 4'h4;
  localparam logic [3:0] TSAB_ADR_DEB0 = 4'h5;
  localparam logic [3:0] TSAB_ADR_DEBN = 4'h6;
  localparam logic [3:0] TSAB_ADR_BUZ_CFG = 4'h7;
  localparam logic [3:0] TSAB_ADR_BUZ_ON = 4'h8;
  localparam logic [3:0] TSAB_ADR_HOST_MODE = 4'h9;
  localparam logic [3:0] TSAB_ADR_SENS_LOW = 4'hA;
  localparam logic [3:0] TSAB_ADR_SENS_HIGH = 4'hB;
  localparam logic [3:0] TSAB_ADR_SENS_TOP = 4'hC;
  localparam logic [3:0] TSAB_ADR_SCAN = 4'hD;
  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] TSAB_RST_DEB = 8'h01;
  localparam logic [7:0] TSAB_RST_BUZ_ON = 8'h01;
  localparam logic [7:0] TSAB_RST_SCAN = 8'h0A;
  localparam int unsigned TSAB_HM_DEEP = 0;
  localparam int unsigned TSAB_HM_ANALOG = 1;
  localparam int unsigned TSAB_HM_GPO0 = 2;
  localparam int unsigned TSAB_HM_GPO1 = 3;
  // Buzzer config: [1:0] mode, [2] idle level, [5:3] frequency, [7:6] duty
  localparam int unsigned TSAB_BZ_IDLE = 2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned TSAB_PWM_STEPS = 10;
  localparam int unsigned TSAB_SCAN_UNIT_US = 1000;
  localparam int unsigned TSAB_SCAN_UNIT_CYC = TSAB_CLK_HZ / 1000000 * TSAB_SCAN_UNIT_US;
  // Full periods in clock cycles of tone 1.00 .. 4.00 kHz, eight phases each
  localparam logic [15:0] TSAB_TONE_PER [7] = '{16'h2710, 16'h2222, 16'h1D4C, 16'h186A,
                                                16'h1388, 16'h0EA6, 16'h09C4};
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TSAB_BZ_NONE, TSAB_BZ_ONE, TSAB_BZ_TWO, TSAB_BZ_RSVD} tsab_bzmode_t;
  typedef enum logic [1:0] {TSAB_SBY_0, TSAB_SBY_20, TSAB_SBY_30, TSAB_SBY_50} tsab_sby_t;
  typedef enum {TSAB_RUN, TSAB_SLEEP, TSAB_DEEP} tsab_pwr_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tsab_bus_t;
endpackage

// >>> tsab_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Standby LED level: 0, 20, 30, 50%
// - Idle released button shows standby level
// - Nonzero standby level blocks low-power sleep
// - Deep sleep stops standby LED drive
// - Report live and latched touch per button
// - Notify line open-drain, pulled low only
// - Sleep when line high, never when low
// - Pull line low while any button touched
// - Host pulls line low before transfers
// - Low line wakes device from deep sleep
// - Analog mode: outputs open-drain, no LED
// - Touch qualified after debounce scan count
// - One debounce for button zero, shared rest
// - One-pin mode: tone on first pin
// - Two-pin mode: antiphase tones on both
// - No buzzer: pins are host outputs
// - Pins idle at level after on-time
// - Seven selectable tone frequencies
// - On-time 1..127 scan periods
// - Any new touch restarts on-time
module tsab_core
  import tsab_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [TSAB_NBTN-1:0] touch_input_n,
  output logic [TSAB_NBTN-1:0] button_output_n,
  output logic [TSAB_NBTN-1:0] button_output_oe,
  input wire logic notify_in,
  output logic notify_out,
  output logic notify_oe,
  output logic tone_pin_first,
  output logic tone_pin_second,
  output logic host_gpo0,
  output logic host_gpo1,
  output logic sleep_state,
  output logic deep_state
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [3:0] sby_steps(input logic [1:0] lvl);
    case (lvl)
      2'h1: sby_steps = 4'h2;
      2'h2: sby_steps = 4'h3;
      2'h3: sby_steps = 4'h5;
      default: sby_steps = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] deb_of(input int unsigned idx, input logic [7:0] d0, input logic [7:0] dn);
    deb_of = (idx == 0) ? d0 : dn;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [TSAB_NBTN-1:0] touch_s1_ff, touch_s2_ff;
  logic notify_s1_ff, notify_s2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      touch_s1_ff <= '1;
      touch_s2_ff <= '1;
      notify_s1_ff <= 1'b1;
      notify_s2_ff <= 1'b1;
    end else begin
      touch_s1_ff <= touch_input_n;
      touch_s2_ff <= touch_s1_ff;
      notify_s1_ff <= notify_in;
      notify_s2_ff <= notify_s1_ff;
    end
  end
  wire logic [TSAB_NBTN-1:0] raw_touch = ~touch_s2_ff;
  wire logic line_low = ~notify_s2_ff;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  tsab_bus_t req;
  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
  logic [7:0] led_cfg_ff, deb0_ff, debn_ff, buz_cfg_ff, buz_on_ff, host_mode_ff, scan_ff;
  logic [7:0] sens_low_ff, sens_high_ff, sens_top_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_cfg_ff <= 8'h00;
      deb0_ff <= TSAB_RST_DEB;
      debn_ff <= TSAB_RST_DEB;
      buz_cfg_ff <= 8'h00;
      buz_on_ff <= TSAB_RST_BUZ_ON;
      host_mode_ff <= 8'h00;
      scan_ff <= TSAB_RST_SCAN;
      sens_low_ff <= 8'h00;
      sens_high_ff <= 8'h00;
      sens_top_ff <= 8'h00;
    end else if (req.wr) begin
      case (req.addr)
        TSAB_ADR_LED_CFG: led_cfg_ff <= {6'h00, req.wdata[1:0]};
        TSAB_ADR_DEB0: deb0_ff <= (req.wdata == 8'h00) ? 8'h01 : req.wdata;
        TSAB_ADR_DEBN: debn_ff <= (req.wdata == 8'h00) ? 8'h01 : req.wdata;
        TSAB_ADR_BUZ_CFG: buz_cfg_ff <= req.wdata;
        TSAB_ADR_BUZ_ON: buz_on_ff <= (req.wdata[6:0] == 7'h00) ? 8'h01 : {1'b0, req.wdata[6:0]};
        TSAB_ADR_HOST_MODE: host_mode_ff <= {4'h0, req.wdata[3:0]};
        TSAB_ADR_SENS_LOW: sens_low_ff <= req.wdata;
        TSAB_ADR_SENS_HIGH: sens_high_ff <= req.wdata;
        TSAB_ADR_SENS_TOP: sens_top_ff <= {4'h0, req.wdata[3:0]};
        TSAB_ADR_SCAN: scan_ff <= (req.wdata == 8'h00) ? 8'h01 : req.wdata;
        default: ;
      endcase
    end
  end
  wire tsab_bzmode_t bz_mode = tsab_bzmode_t'(buz_cfg_ff[1:0]);
  wire logic bz_idle = buz_cfg_ff[TSAB_BZ_IDLE];

  // ---------------------------------------------------------------
  // Scan tick
  // ---------------------------------------------------------------
  logic [23:0] scan_cnt_ff;
  logic scan_tick_ff;
  wire logic [23:0] scan_len = 24'(scan_ff) * 24'(TSAB_SCAN_UNIT_CYC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_ff <= 24'h000000;
      scan_tick_ff <= 1'b0;
    end else begin
      scan_tick_ff <= (scan_cnt_ff == scan_len - 24'h000001);
      scan_cnt_ff <= (scan_cnt_ff >= scan_len - 24'h000001) ? 24'h000000 : scan_cnt_ff + 24'h000001;
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  tsab_pwr_t pwr_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= TSAB_RUN;
    end else begin
      case (pwr_ff)
        TSAB_RUN: begin
          if (!line_low && host_mode_ff[TSAB_HM_DEEP]) begin
            pwr_ff <= TSAB_DEEP;
          end else if (!line_low && led_cfg_ff[1:0] == 2'h0) begin
            pwr_ff <= TSAB_SLEEP;
          end
        end
        TSAB_SLEEP: begin
          if (line_low || led_cfg_ff[1:0] != 2'h0) begin
            pwr_ff <= TSAB_RUN;
          end else if (host_mode_ff[TSAB_HM_DEEP]) begin
            pwr_ff <= TSAB_DEEP;
          end
        end
        TSAB_DEEP: begin
          if (line_low) begin
            pwr_ff <= TSAB_RUN;
          end
        end
        default: pwr_ff <= TSAB_RUN;
      endcase
    end
  end
  wire logic deep = (pwr_ff == TSAB_DEEP);

  // ---------------------------------------------------------------
  // Debounce and touch status
  // ---------------------------------------------------------------
  logic [7:0] deb_cnt_ff [TSAB_NBTN];
  logic [TSAB_NBTN-1:0] live_ff, held_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < TSAB_NBTN; i++) begin
        deb_cnt_ff[i] <= 8'h00;
      end
      live_ff <= '0;
    end else if (deep) begin
      for (int i = 0; i < TSAB_NBTN; i++) begin
        deb_cnt_ff[i] <= 8'h00;
      end
      live_ff <= '0;
    end else if (scan_tick_ff) begin
      for (int i = 0; i < TSAB_NBTN; i++) begin
        if (!raw_touch[i]) begin
          deb_cnt_ff[i] <= 8'h00;
          live_ff[i] <= 1'b0;
        end else if (deb_cnt_ff[i] + 8'h01 >= deb_of(i, deb0_ff, debn_ff)) begin
          live_ff[i] <= 1'b1;
        end else begin
          deb_cnt_ff[i] <= deb_cnt_ff[i] + 8'h01;
        end
      end
    end
  end
  wire logic [TSAB_NBTN-1:0] rd_clr = {{2{req.rd && req.addr == TSAB_ADR_HELD_HIGH}},
                                       {8{req.rd && req.addr == TSAB_ADR_HELD_LOW}}};
  logic [TSAB_NBTN-1:0] live_d_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_d_ff <= '0;
      held_ff <= '0;
    end else begin
      live_d_ff <= live_ff;
      held_ff <= (held_ff & ~rd_clr) | (live_ff & ~live_d_ff);
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        TSAB_ADR_LIVE_LOW: bus_rdata <= live_ff[7:0];
        TSAB_ADR_LIVE_HIGH: bus_rdata <= {6'h00, live_ff[9:8]};
        TSAB_ADR_HELD_LOW: bus_rdata <= held_ff[7:0];
        TSAB_ADR_HELD_HIGH: bus_rdata <= {6'h00, held_ff[9:8]};
        TSAB_ADR_LED_CFG: bus_rdata <= led_cfg_ff;
        TSAB_ADR_DEB0: bus_rdata <= deb0_ff;
        TSAB_ADR_DEBN: bus_rdata <= debn_ff;
        TSAB_ADR_BUZ_CFG: bus_rdata <= buz_cfg_ff;
        TSAB_ADR_BUZ_ON: bus_rdata <= buz_on_ff;
        TSAB_ADR_HOST_MODE: bus_rdata <= host_mode_ff;
        TSAB_ADR_SENS_LOW: bus_rdata <= sens_low_ff;
        TSAB_ADR_SENS_HIGH: bus_rdata <= sens_high_ff;
        TSAB_ADR_SENS_TOP: bus_rdata <= sens_top_ff;
        TSAB_ADR_SCAN: bus_rdata <= scan_ff;
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Notify line and power outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      notify_out <= 1'b0;
      notify_oe <= 1'b0;
      sleep_state <= 1'b0;
      deep_state <= 1'b0;
    end else begin
      notify_out <= 1'b0;
      notify_oe <= |live_ff;
      sleep_state <= (pwr_ff == TSAB_SLEEP);
      deep_state <= deep;
    end
  end

  // ---------------------------------------------------------------
  // LED standby dimming
  // ---------------------------------------------------------------
  logic [3:0] pwm_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_ff <= 4'h0;
    end else begin
      pwm_ff <= (pwm_ff == 4'(TSAB_PWM_STEPS - 1)) ? 4'h0 : pwm_ff + 4'h1;
    end
  end
  wire logic sby_on = (pwm_ff < sby_steps(led_cfg_ff[1:0]));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      button_output_n <= '1;
      button_output_oe <= '0;
    end else begin
      for (int i = 0; i < TSAB_NBTN; i++) begin
        if (host_mode_ff[TSAB_HM_ANALOG]) begin
          button_output_n[i] <= 1'b0;
          button_output_oe[i] <= live_ff[i];
        end else if (live_ff[i]) begin
          button_output_n[i] <= 1'b0;
          button_output_oe[i] <= 1'b1;
        end else begin
          button_output_n[i] <= !(sby_on && !deep);
          button_output_oe[i] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Buzzer
  // ---------------------------------------------------------------
  logic [15:0] tone_cnt_ff;
  logic [2:0] tone_ph_ff;
  logic [7:0] on_cnt_ff;
  wire logic [15:0] tone_step = TSAB_TONE_PER[(buz_cfg_ff[5:3] > 3'h6) ? 3'h6 : buz_cfg_ff[5:3]] >> 3;
  wire logic new_touch = |(live_ff & ~live_d_ff);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_cnt_ff <= 16'h0000;
      tone_ph_ff <= 3'h0;
    end else if (tone_cnt_ff >= tone_step - 16'h0001) begin
      tone_cnt_ff <= 16'h0000;
      tone_ph_ff <= tone_ph_ff + 3'h1;
    end else begin
      tone_cnt_ff <= tone_cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt_ff <= 8'h00;
    end else if (new_touch) begin
      on_cnt_ff <= buz_on_ff;
    end else if (live_ff == '0 || deep) begin
      on_cnt_ff <= 8'h00;
    end else if (scan_tick_ff && on_cnt_ff != 8'h00) begin
      on_cnt_ff <= on_cnt_ff - 8'h01;
    end
  end
  wire logic wave = (tone_ph_ff < {1'b0, buz_cfg_ff[7:6]} + 3'h2);
  wire logic sounding = (on_cnt_ff != 8'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_pin_first <= 1'b0;
      tone_pin_second <= 1'b0;
      host_gpo0 <= 1'b0;
      host_gpo1 <= 1'b0;
    end else begin
      host_gpo0 <= host_mode_ff[TSAB_HM_GPO0];
      host_gpo1 <= host_mode_ff[TSAB_HM_GPO1];
      case (bz_mode)
        TSAB_BZ_ONE: begin
          tone_pin_first <= sounding ? wave : bz_idle;
          tone_pin_second <= host_mode_ff[TSAB_HM_GPO1];
        end
        TSAB_BZ_TWO: begin
          tone_pin_first <= sounding ? wave : bz_idle;
          tone_pin_second <= sounding ? !wave : bz_idle;
        end
        default: begin
          tone_pin_first <= host_mode_ff[TSAB_HM_GPO0];
          tone_pin_second <= host_mode_ff[TSAB_HM_GPO1];
        end
      endcase
    end
  end
endmodule

// >>> tsab_core_sva.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module tsab_core_sva
  import tsab_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [TSAB_NBTN-1:0] touch_input_n,
  input wire logic [TSAB_NBTN-1:0] button_output_n,
  input wire logic [TSAB_NBTN-1:0] button_output_oe,
  input wire logic notify_in,
  input wire logic notify_out,
  input wire logic notify_oe,
  input wire logic tone_pin_first,
  input wire logic tone_pin_second,
  input wire logic host_gpo0,
  input wire logic host_gpo1,
  input wire logic sleep_state,
  input wire logic deep_state
);
  logic [7:0] bz_ff;
  logic [1:0] led_ff;
  logic [3:0] hm_ff;
  // Shadow copies of the settings written over the port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bz_ff <= 8'h00;
      led_ff <= 2'h0;
      hm_ff <= 4'h0;
    end else if (bus_wr) begin
      if (bus_addr == TSAB_ADR_BUZ_CFG) begin
        bz_ff <= bus_wdata;
      end
      if (bus_addr == TSAB_ADR_LED_CFG) begin
        led_ff <= bus_wdata[1:0];
      end
      if (bus_addr == TSAB_ADR_HOST_MODE) begin
        hm_ff <= bus_wdata[3:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_od_low_only: assert property (notify_out == 1'h0)
    else $error("notify line driven high");
  a_sleep_line_low: assert property (!notify_in [*5] |-> !sleep_state)
    else $error("sleep with notify line low");
  a_wake_line_low: assert property (!notify_in [*5] |-> !deep_state)
    else $error("deep sleep with notify line low");
  a_deep_dark: assert property (deep_state [*3] |-> &button_output_n)
    else $error("button output lit in deep sleep");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_tone_antiphase: assert property (bz_ff[1:0] == 2'h2 && $past(bz_ff, 2) == bz_ff &&
    (tone_pin_first != bz_ff[TSAB_BZ_IDLE] || tone_pin_second != bz_ff[TSAB_BZ_IDLE])
    |-> tone_pin_first != tone_pin_second)
    else $error("two pin tone not in antiphase");
  a_sleep_dim: assert property (led_ff != 2'h0 && $past(led_ff, 3) == led_ff |-> !sleep_state)
    else $error("sleep with standby level on");
  a_gpo_follow: assert property (bus_wr && bus_addr == TSAB_ADR_HOST_MODE |=> ##1
    host_gpo0 == $past(bus_wdata[TSAB_HM_GPO0], 2) && host_gpo1 == $past(bus_wdata[TSAB_HM_GPO1], 2))
    else $error("host outputs not following setting");
  a_analog_od: assert property (hm_ff[TSAB_HM_ANALOG] && $past(hm_ff, 2) == hm_ff
    |-> (button_output_oe & button_output_n) == '0)
    else $error("analog output driven high");
endmodule
bind tsab_core tsab_core_sva tsab_core_sva_inst (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .touch_input_n(touch_input_n), .button_output_n(button_output_n), .button_output_oe(button_output_oe),
  .notify_in(notify_in), .notify_out(notify_out), .notify_oe(notify_oe), .tone_pin_first(tone_pin_first),
  .tone_pin_second(tone_pin_second), .host_gpo0(host_gpo0), .host_gpo1(host_gpo1),
  .sleep_state(sleep_state), .deep_state(deep_state));

// >>> tsab_host_model.sv
`timescale 1ns/1ps
// ----
// Host side of the notify line
// ----
module tsab_host_model
  import tsab_pkg::*;
#(
  parameter int unsigned DEEP_WAIT = 500000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pull_req,
  input wire logic deep_req,
  input wire logic notify_oe,
  input wire logic notify_out,
  output logic notify_in
);
  logic low_ff;
  logic [19:0] cnt_ff;
  // Pull-up: a released line reads high, any pull makes it low
  assign notify_in = !(low_ff || (notify_oe && !notify_out));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 20'h00000;
      low_ff <= 1'h0;
    end else if (deep_req) begin
      if (cnt_ff < DEEP_WAIT) begin
        cnt_ff <= cnt_ff + 20'h00001;
      end
      // Keep the line low for the wait, then release it
      low_ff <= (cnt_ff < DEEP_WAIT);
    end else begin
      cnt_ff <= 20'h00000;
      low_ff <= pull_req;
    end
  end
endmodule

// >>> tsab_core_tb_top.sv
`timescale 1ns/1ps
module tsab_core_tb_top
  import tsab_pkg::*;
;
  logic clk, rst_n, bus_wr, bus_rd, pull_req, deep_req;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata;
  logic [TSAB_NBTN-1:0] touch_input_n, button_output_n, button_output_oe;
  logic notify_in, notify_out, notify_oe, tone_pin_first, tone_pin_second;
  logic host_gpo0, host_gpo1, sleep_state, deep_state;
  int n_fail = 0;
  int n_tests = 0;
  int k;
  always #50 clk = ~clk;
  tsab_core tsab_core_inst (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .touch_input_n(touch_input_n),
    .button_output_n(button_output_n), .button_output_oe(button_output_oe), .notify_in(notify_in),
    .notify_out(notify_out), .notify_oe(notify_oe), .tone_pin_first(tone_pin_first),
    .tone_pin_second(tone_pin_second), .host_gpo0(host_gpo0), .host_gpo1(host_gpo1),
    .sleep_state(sleep_state), .deep_state(deep_state));
  tsab_host_model #(.DEEP_WAIT(50)) tsab_host_model_inst (.clk(clk), .rst_n(rst_n), .pull_req(pull_req),
    .deep_req(deep_req), .notify_oe(notify_oe), .notify_out(notify_out), .notify_in(notify_in));
  // ----
  // Tasks
  // ----
  task give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge clk);
    bus_wr <= 1'h0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clk);
    bus_rd <= 1'h0;
    #1;
    chk($sformatf("rdata %0h", a), {8'h00, e}, {8'h00, bus_rdata});
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = notify_oe;
      1: pick = deep_state;
      2: pick = sleep_state;
      default: pick = tone_pin_first;
    endcase
  endfunction
  task waitv(input int s, input logic v, input int lim);
    int i;
    i = 0;
    #1;
    while (pick(s) !== v && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk($sformatf("wait %0d", s), {15'h0000, v}, {15'h0000, pick(s)});
    if (i >= lim) begin
      give_verdict();
    end
  endtask
  task tone_meas(input logic [15:0] hi, input logic [15:0] per);
    logic [15:0] c;
    logic s2;
    c = 16'h0000;
    s2 = tone_pin_second;
    repeat (2) @(posedge clk);
    waitv(3, 1'h0, 12000);
    waitv(3, 1'h1, 12000);
    while (tone_pin_first === 1'h1 && c < 16'h4E20) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("tone high", hi, c);
    while (tone_pin_first === 1'h0 && c < 16'h4E20) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("tone period", per, c);
    chk("second pin", {15'h0000, s2}, {15'h0000, tone_pin_second});
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    pull_req = 1'h0;
    deep_req = 1'h0;
    touch_input_n = '1;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    pull_req <= 1'h1;
    rdc(TSAB_ADR_LIVE_LOW, 8'h00);
    rdc(TSAB_ADR_HELD_LOW, 8'h00);
    rdc(4'hE, 8'h00);
    rdc(TSAB_ADR_SCAN, TSAB_RST_SCAN);
    rdc(TSAB_ADR_DEB0, TSAB_RST_DEB);
    wr(TSAB_ADR_DEB0, 8'h00);
    rdc(TSAB_ADR_DEB0, 8'h01);
    wr(TSAB_ADR_DEBN, 8'hFF);
    rdc(TSAB_ADR_DEBN, 8'hFF);
    rdc(TSAB_ADR_DEB0, 8'h01);
    for (k = 0; k < 4; k++) begin
      wr(TSAB_ADR_LED_CFG, k[7:0]);
      rdc(TSAB_ADR_LED_CFG, k[7:0]);
    end
    wr(TSAB_ADR_HOST_MODE, 8'h0C);
    repeat (3) @(posedge clk);
    #1;
    chk("host outputs", 16'h0003, {14'h0000, host_gpo1, host_gpo0});
    wr(TSAB_ADR_LED_CFG, 8'h00);
    wr(TSAB_ADR_SCAN, 8'h01);
    wr(TSAB_ADR_DEB0, 8'h01);
    wr(TSAB_ADR_DEBN, 8'h01);
    wr(TSAB_ADR_BUZ_ON, 8'h02);
    wr(TSAB_ADR_BUZ_CFG, 8'h61);
    touch_input_n <= 10'h3FE;
    waitv(0, 1'h1, 30000);
    tone_meas(16'(TSAB_TONE_PER[4] * 3 / 8), TSAB_TONE_PER[4]);
    rdc(TSAB_ADR_LIVE_LOW, 8'h01);
    rdc(TSAB_ADR_HELD_LOW, 8'h01);
    rdc(TSAB_ADR_HELD_LOW, 8'h00);
    rdc(TSAB_ADR_LIVE_LOW, 8'h01);
    repeat (16000) @(posedge clk);
    #1;
    chk("idle pin", 16'h0000, {15'h0000, tone_pin_first});
    wr(TSAB_ADR_BUZ_CFG, 8'h62);
    touch_input_n <= 10'h1FE;
    waitv(3, 1'h1, 30000);
    chk("antiphase pin", 16'h0000, {15'h0000, tone_pin_second});
    rdc(TSAB_ADR_HELD_HIGH, 8'h02);
    @(posedge clk);
    touch_input_n <= '1;
    waitv(0, 1'h0, 30000);
    repeat (2) @(posedge clk);
    #1;
    chk("released pins", 16'h0000, {14'h0000, tone_pin_second, tone_pin_first});
    wr(TSAB_ADR_LED_CFG, 8'h03);
    wr(TSAB_ADR_HOST_MODE, 8'h01);
    deep_req <= 1'h1;
    waitv(1, 1'h1, 2000);
    chk("deep outputs", {6'h00, 10'h3FF}, {6'h00, button_output_n});
    @(posedge clk);
    deep_req <= 1'h0;
    waitv(1, 1'h0, 200);
    wr(TSAB_ADR_LED_CFG, 8'h00);
    wr(TSAB_ADR_HOST_MODE, 8'h00);
    pull_req <= 1'h0;
    waitv(2, 1'h1, 200);
    @(posedge clk);
    pull_req <= 1'h1;
    waitv(2, 1'h0, 200);
    wr(TSAB_ADR_LED_CFG, 8'h03);
    pull_req <= 1'h0;
    repeat (50) @(posedge clk);
    #1;
    chk("dim sleep", 16'h0000, {15'h0000, sleep_state});
    @(posedge clk);
    pull_req <= 1'h1;
    wr(TSAB_ADR_HOST_MODE, 8'h02);
    repeat (20) @(posedge clk);
    #1;
    chk("analog oe", 16'h0000, {6'h00, button_output_oe});
    give_verdict();
  end
endmodule
